// ---- design/flm_consts.vh ----
// constants for the loop modem: clock rates, tone steps, thresholds, timing
// included by the modem top and its sine table; definitions only
`ifndef FLM_CONSTS_VH
`define FLM_CONSTS_VH

// system clock and derived sample rate
`define FLM_CLK_HZ        25000000
`define FLM_FS_HZ         40000
`define FLM_SAMPLE_DIV    (`FLM_CLK_HZ / `FLM_FS_HZ)
`define FLM_DIV_W         10

// nominal crystal or external clock on the oscillator pins, in kHz
`define FLM_OSC_KHZ       3686

// tone frequencies and phase steps of the 16-bit accumulator
`define FLM_MARK_HZ       1200
`define FLM_SPACE_HZ      2200
`define FLM_PHASE_W       16
`define FLM_MARK_STEP     ((`FLM_MARK_HZ * 65536) / `FLM_FS_HZ)
`define FLM_SPACE_STEP    ((`FLM_SPACE_HZ * 65536) / `FLM_FS_HZ)

// bit slot and the crossing-period split between mark and space
`define FLM_BIT_US        833
`define FLM_SLOT_SAMPLES  ((`FLM_BIT_US * (`FLM_FS_HZ / 1000)) / 1000)
`define FLM_PER_SPLIT     ((`FLM_FS_HZ / `FLM_MARK_HZ + `FLM_FS_HZ / `FLM_SPACE_HZ) / 2)
`define FLM_PER_W         6
`define FLM_PER_MAX       6'h3f

// converter scaling: 8 bits over a 1230 mV span, midscale code
`define FLM_ADC_SPAN_MV   1230
`define FLM_MID_CODE      8'h80
`define FLM_CD_ON_MV      120
`define FLM_CD_OFF_MV     80
`define FLM_CD_ON_CODE    ((`FLM_CD_ON_MV * 256) / `FLM_ADC_SPAN_MV)
`define FLM_CD_OFF_CODE   ((`FLM_CD_OFF_MV * 256) / `FLM_ADC_SPAN_MV)

// amplitude window in samples, longer than one mark period
`define FLM_WIN_SAMPLES   48
`define FLM_WIN_W         6

// internal reset stretch after system reset release
`define FLM_POR_US        100
`define FLM_POR_CYCLES    ((`FLM_POR_US * (`FLM_CLK_HZ / 1000000)))
`define FLM_POR_W         12

`endif

// ---- design/flm_sine_rom.v ----
// quarter-wave sine magnitude table for the tone generator
// assumes the caller folds phase into one quadrant; data lag one clock
`timescale 1ns/10ps
`default_nettype none
`include "flm_consts.vh"

module flm_sine_rom (
  // clock
  input  wire       clk,
  // lookup
  input  wire [3:0] addr,
  output reg  [6:0] data
);

  // registered read keeps the table off the output path
  always @(posedge clk) begin
    case (addr)
      4'h0:    data <= 7'h06;
      4'h1:    data <= 7'h13;
      4'h2:    data <= 7'h1f;
      4'h3:    data <= 7'h2b;
      4'h4:    data <= 7'h36;
      4'h5:    data <= 7'h41;
      4'h6:    data <= 7'h4c;
      4'h7:    data <= 7'h55;
      4'h8:    data <= 7'h5e;
      4'h9:    data <= 7'h66;
      4'ha:    data <= 7'h6d;
      4'hb:    data <= 7'h73;
      4'hc:    data <= 7'h78;
      4'hd:    data <= 7'h7b;
      4'he:    data <= 7'h7e;
      4'hf:    data <= 7'h7f;
      default: data <= 7'h00;
    endcase
  end

endmodule
`default_nettype wire

// ---- design/flm_modem.v ----
// half-duplex fsk loop modem: tone generator, tone detector, carrier detect
// assumes a converter pair outside: TONE_IN and TONE_OUT are 8-bit offset codes
`timescale 1ns/10ps
`default_nettype none
`include "flm_consts.vh"

module flm_modem (
  // clock and system reset
  input  wire       CLOCK,
  input  wire       SYS_RST,
  // reset pin, open drain
  input  wire       RESET_N_IN,
  output reg        RESET_N_OUT,
  output reg        RESET_N_OE,
  // host side
  input  wire       REQ_SEND,
  input  wire       TX_DATA,
  output reg        RX_DATA,
  output reg        CARRIER_PRESENT_OUT,
  // oscillator pins
  input  wire       EXT_CLOCK_SELECT,
  input  wire       OSC_IN,
  output reg        OSC_OUT,
  // converter side
  input  wire [7:0] TONE_IN,
  output reg  [7:0] TONE_OUT
);

  // mode states, one-hot
  localparam [2:0] ST_RESET = 3'h1;
  localparam [2:0] ST_RX    = 3'h2;
  localparam [2:0] ST_TX    = 3'h4;

  // integer forms first, cut to register width on purpose below
  localparam integer DIV_LAST_I  = `FLM_SAMPLE_DIV - 1;
  localparam integer POR_LAST_I  = `FLM_POR_CYCLES - 1;
  localparam integer MARK_ST_I   = `FLM_MARK_STEP;
  localparam integer SPACE_ST_I  = `FLM_SPACE_STEP;
  localparam integer PER_SPLIT_I = `FLM_PER_SPLIT;
  localparam integer WIN_LAST_I  = `FLM_WIN_SAMPLES - 1;
  localparam integer CD_ON_I     = `FLM_CD_ON_CODE;
  localparam integer CD_OFF_I    = `FLM_CD_OFF_CODE;

  localparam [`FLM_DIV_W-1:0]   DIV_LAST  = DIV_LAST_I[`FLM_DIV_W-1:0];
  localparam [`FLM_POR_W-1:0]   POR_LAST  = POR_LAST_I[`FLM_POR_W-1:0];
  localparam [`FLM_PHASE_W-1:0] MARK_ST   = MARK_ST_I[`FLM_PHASE_W-1:0];
  localparam [`FLM_PHASE_W-1:0] SPACE_ST  = SPACE_ST_I[`FLM_PHASE_W-1:0];
  localparam [`FLM_PER_W-1:0]   PER_SPLIT = PER_SPLIT_I[`FLM_PER_W-1:0];
  localparam [`FLM_WIN_W-1:0]   WIN_LAST  = WIN_LAST_I[`FLM_WIN_W-1:0];
  localparam [7:0]              CD_ON     = CD_ON_I[7:0];
  localparam [7:0]              CD_OFF    = CD_OFF_I[7:0];

  reg  [`FLM_POR_W-1:0]   por_cnt_r;
  reg                     por_act_r;
  reg                     pin_n_r;
  reg  [2:0]              state_r;
  reg  [2:0]              state_nxt;
  reg  [`FLM_DIV_W-1:0]   div_r;
  reg                     smp_en_r;
  reg  [`FLM_PHASE_W-1:0] phase_r;
  reg  [1:0]              quad_r;
  reg                     tx_live_r;
  wire [6:0]              sine_mag;
  reg                     sign_r;
  reg  [`FLM_PER_W-1:0]   per_r;
  reg  [7:0]              max_r;
  reg  [7:0]              min_r;
  reg  [`FLM_WIN_W-1:0]   win_r;
  reg                     bit_r;
  wire                    modem_rst;
  wire                    pos_now;
  wire [7:0]              pp_span;

  // combine a step choice: mark for one, space for zero
  function [`FLM_PHASE_W-1:0] step_for;
    input level;
    begin
      step_for = level ? MARK_ST : SPACE_ST;
    end
  endfunction

  // internal reset: stretch after system reset, pin forced low meanwhile
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      por_cnt_r   <= {`FLM_POR_W{1'b0}};
      por_act_r   <= 1'b1;
      RESET_N_OUT <= 1'b0;
      RESET_N_OE  <= 1'b1;
      pin_n_r     <= 1'b0;
    end else begin
      pin_n_r <= RESET_N_IN;
      if (por_act_r) begin
        if (por_cnt_r == POR_LAST)
          por_act_r <= 1'b0;
        por_cnt_r <= por_cnt_r + 1'b1;
      end
      RESET_N_OUT <= 1'b0;
      RESET_N_OE  <= por_act_r && (por_cnt_r != POR_LAST);
    end
  end

  // external pin low holds the modem, even when another party pulls it
  assign modem_rst = por_act_r | ~pin_n_r;

  // direction follows the request level; only the system, internal or pin reset overrides it, forcing ST_RESET
  always @* begin
    case (state_r)
      ST_RESET: state_nxt = REQ_SEND ? ST_RX : ST_TX;
      ST_RX:    state_nxt = REQ_SEND ? ST_RX : ST_TX;
      ST_TX:    state_nxt = REQ_SEND ? ST_RX : ST_TX;
      default:  state_nxt = ST_RESET;
    endcase
  end

  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      state_r <= ST_RESET;
    else if (modem_rst)
      state_r <= ST_RESET;
    else
      state_r <= state_nxt;
  end

  // sample-rate enable, one pulse per converter sample
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div_r    <= {`FLM_DIV_W{1'b0}};
      smp_en_r <= 1'b0;
    end else begin
      smp_en_r <= (div_r == DIV_LAST);
      if (div_r == DIV_LAST)
        div_r <= {`FLM_DIV_W{1'b0}};
      else
        div_r <= div_r + 1'b1;
    end
  end

  // crystal amplifier: inverts osc_in; idle low when an external clock is used
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      OSC_OUT <= 1'b0;
    else
      OSC_OUT <= EXT_CLOCK_SELECT ? 1'b0 : ~OSC_IN;
  end

  // phase accumulator: only the step changes, so no phase jump at a bit edge
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase_r   <= {`FLM_PHASE_W{1'b0}};
      quad_r    <= 2'h0;
      tx_live_r <= 1'b0;
    end else if (state_r != ST_TX) begin
      phase_r   <= {`FLM_PHASE_W{1'b0}};
      tx_live_r <= 1'b0;
    end else begin
      // quadrant trails the phase by one clock, like the registered table read
      quad_r <= phase_r[15:14];
      if (smp_en_r) begin
        phase_r   <= phase_r + step_for(TX_DATA);
        tx_live_r <= 1'b1;
      end
    end
  end

  // quadrant fold: mirror the index in odd quadrants
  flm_sine_rom u_rom (
    .clk  (CLOCK),
    .addr (phase_r[14] ? ~phase_r[13:10] : phase_r[13:10]),
    .data (sine_mag)
  );

  // dac code: midscale while receiving, so only one direction is ever active
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      TONE_OUT <= `FLM_MID_CODE;
    else if (!tx_live_r || state_r != ST_TX)
      TONE_OUT <= `FLM_MID_CODE;
    else if (quad_r[1])
      TONE_OUT <= `FLM_MID_CODE - {1'b0, sine_mag};
    else
      TONE_OUT <= `FLM_MID_CODE + {1'b0, sine_mag};
  end

  // receive path: a rising midscale crossing ends one tone period
  assign pos_now = (TONE_IN >= `FLM_MID_CODE);
  assign pp_span = max_r - min_r;

  // period split sits halfway between mark and space, well inside one slot
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sign_r <= 1'b0;
      per_r  <= {`FLM_PER_W{1'b0}};
      bit_r  <= 1'b1;
    end else if (state_r != ST_RX) begin
      sign_r <= 1'b0;
      per_r  <= {`FLM_PER_W{1'b0}};
      bit_r  <= 1'b1;
    end else if (smp_en_r) begin
      sign_r <= pos_now;
      if (pos_now && !sign_r) begin
        bit_r <= (per_r > PER_SPLIT);
        per_r <= {`FLM_PER_W{1'b0}};
      end else if (per_r != `FLM_PER_MAX) begin
        per_r <= per_r + 1'b1;
      end
    end
  end

  // amplitude window: peak-to-peak over a fixed run of samples
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      max_r               <= `FLM_MID_CODE;
      min_r               <= `FLM_MID_CODE;
      win_r               <= {`FLM_WIN_W{1'b0}};
      CARRIER_PRESENT_OUT <= 1'b0;
    end else if (state_r != ST_RX) begin
      max_r               <= `FLM_MID_CODE;
      min_r               <= `FLM_MID_CODE;
      win_r               <= {`FLM_WIN_W{1'b0}};
      CARRIER_PRESENT_OUT <= 1'b0;
    end else if (smp_en_r) begin
      if (win_r == WIN_LAST) begin
        win_r <= {`FLM_WIN_W{1'b0}};
        max_r <= TONE_IN;
        min_r <= TONE_IN;
        if (pp_span > CD_ON)
          CARRIER_PRESENT_OUT <= 1'b1;
        else if (pp_span < CD_OFF)
          CARRIER_PRESENT_OUT <= 1'b0;
        else
          CARRIER_PRESENT_OUT <= CARRIER_PRESENT_OUT;
      end else begin
        win_r <= win_r + 1'b1;
        if (TONE_IN > max_r)
          max_r <= TONE_IN;
        if (TONE_IN < min_r)
          min_r <= TONE_IN;
      end
    end
  end

  // data out: raw recovered bits, no framing; idle high when no carrier
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      RX_DATA <= 1'b1;
    else if (state_r != ST_RX)
      RX_DATA <= 1'b1;
    else
      RX_DATA <= CARRIER_PRESENT_OUT ? bit_r : 1'b1;
  end

endmodule
`default_nettype wire

// ---- bench/flm_checker.sv ----
// checker for the loop modem top: reset pin, mode gating, oscillator, tone
// bound to every flm_modem; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module flm_checker (
  // clock and reset pin
  input wire logic       CLOCK,
  input wire logic       SYS_RST,
  input wire logic       RESET_N_IN,
  input wire logic       RESET_N_OUT,
  input wire logic       RESET_N_OE,
  // host side
  input wire logic       REQ_SEND,
  input wire logic       RX_DATA,
  input wire logic       CARRIER_PRESENT_OUT,
  // oscillator and converter
  input wire logic       EXT_CLOCK_SELECT,
  input wire logic       OSC_IN,
  input wire logic       OSC_OUT,
  input wire logic [7:0] TONE_OUT
);
  logic [11:0] since_r;
  logic [2:0]  pin_r;
  // cycles since release, saturating so it never wraps into the window
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      since_r <= 12'h000;
      pin_r   <= 3'h0;
    end else begin
      since_r <= (since_r == 12'hfff) ? since_r : since_r + 12'h001;
      pin_r   <= {pin_r[1:0], RESET_N_IN};
    end
  end
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  a_pin_low_only: assert property (RESET_N_OE |-> !RESET_N_OUT)
    else $error("reset pin driven high");
  a_stretch_hold: assert property (since_r < 12'h9c4 |-> RESET_N_OE)
    else $error("reset stretch ended early");
  a_stretch_end: assert property (since_r >= 12'h9c4 |-> !RESET_N_OE)
    else $error("reset pin still pulled low");
  a_osc_follow: assert property (pin_r == 3'h7 && !EXT_CLOCK_SELECT
    && $past(!EXT_CLOCK_SELECT) |-> OSC_OUT == !$past(OSC_IN))
    else $error("oscillator output not inverted input");
  a_osc_parked: assert property (EXT_CLOCK_SELECT [*2] |-> !OSC_OUT)
    else $error("oscillator output not parked");
  a_rx_idle_tx: assert property (!REQ_SEND [*3] |-> RX_DATA)
    else $error("receive data active in transmit");
  a_tone_idle_rx: assert property (REQ_SEND [*3] |-> TONE_OUT == 8'h80)
    else $error("tone output active in receive");
  a_cd_tx_off: assert property (!REQ_SEND [*3] |-> !CARRIER_PRESENT_OUT)
    else $error("carrier flag set in transmit");
  a_nocd_mark: assert property (!CARRIER_PRESENT_OUT [*3] |-> RX_DATA)
    else $error("receive data low without carrier");
  a_pin_idle: assert property ($fell(pin_r[0])
    |-> ##[1:3] (RX_DATA && TONE_OUT == 8'h80))
    else $error("outputs not idle under pin reset");
  // a phase jump shows as a step larger than the fastest tone allows
  a_phase_cont: assert property (!REQ_SEND [*4] ##0 (pin_r == 3'h7
    && TONE_OUT != $past(TONE_OUT)) |-> (TONE_OUT > $past(TONE_OUT) ?
    TONE_OUT - $past(TONE_OUT) : $past(TONE_OUT) - TONE_OUT) <= 8'h38)
    else $error("tone step too large");
  c_tone: cover property (!REQ_SEND && $changed(TONE_OUT));
  c_carrier: cover property ($rose(CARRIER_PRESENT_OUT));
  c_pin: cover property ($fell(pin_r[0]));
endmodule
bind flm_modem flm_checker u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .RESET_N_IN(RESET_N_IN), .RESET_N_OUT(RESET_N_OUT), .RESET_N_OE(RESET_N_OE),
  .REQ_SEND(REQ_SEND), .RX_DATA(RX_DATA), .CARRIER_PRESENT_OUT(CARRIER_PRESENT_OUT),
  .EXT_CLOCK_SELECT(EXT_CLOCK_SELECT), .OSC_IN(OSC_IN), .OSC_OUT(OSC_OUT),
  .TONE_OUT(TONE_OUT));
`default_nettype wire

// ---- bench/flm_host.sv ----
// host uart model: sends one 11-bit character on the transmit data line
// assumes the modem samples the line; driven at the falling edge
`timescale 1ns/10ps
`default_nettype none
module flm_host #(
  parameter int SLOT = 20825
) (
  // clock and start
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] data,
  // serial line
  output wire logic       tx_data
);
  logic [10:0] sh_r  = 11'h7ff;
  int          cnt_r = 0;
  // idle is mark; start, data lsb first, even parity, stop
  always @(negedge clk) begin
    if (go) begin
      sh_r  <= {1'b1, ^data, data, 1'b0};
      cnt_r <= 0;
    end else if (cnt_r == SLOT - 1) begin
      sh_r  <= {1'b1, sh_r[10:1]};
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  assign tx_data = sh_r[0];
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// top bench for the loop modem: reset, oscillator, tones, receive
// assumes flm_modem, flm_host and the bound checker; 25 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic       clock    = 1'b0;
  logic       sys_rst  = 1'b1;
  logic       req_send = 1'b0;
  logic       ext_sel  = 1'b0;
  logic       osc_in   = 1'b0;
  logic       go       = 1'b0;
  logic       ext_n    = 1'b1;
  logic [7:0] tone_in  = 8'h80;
  wire        tx_data, rx_data, cd, osc_out, oe, drv, pin_n;
  wire  [7:0] tone_out;
  int         err_total   = 0;
  int         check_count = 0;
  // pin has a pull-up; device and board may both pull low
  assign pin_n = (oe ? drv : 1'b1) & ext_n;
  always #20 clock = ~clock;
  always @(negedge clock) osc_in <= ~osc_in;
  // board ties the mode pin high; the modem has no port for it
  flm_modem uut (.CLOCK(clock), .SYS_RST(sys_rst), .RESET_N_IN(pin_n),
    .RESET_N_OUT(drv), .RESET_N_OE(oe), .REQ_SEND(req_send), .TX_DATA(tx_data),
    .RX_DATA(rx_data), .CARRIER_PRESENT_OUT(cd), .EXT_CLOCK_SELECT(ext_sel),
    .OSC_IN(osc_in), .OSC_OUT(osc_out), .TONE_IN(tone_in), .TONE_OUT(tone_out));
  flm_host host (.clk(clock), .go(go), .data(8'ha5), .tx_data(tx_data));
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_rng(string name, int lo, int hi, int got);
    check_count++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // cycles of one positive half wave, skipping any half wave in progress
  task automatic hi_run(output int n);
    int k;
    for (k = 0; k < 30000 && tone_out > 8'h80; k++) @(negedge clock);
    for (k = 0; k < 30000 && tone_out <= 8'h80; k++) @(negedge clock);
    for (n = 0; n < 30000 && tone_out > 8'h80; n++) @(negedge clock);
  endtask
  task automatic t_reset();
    repeat (12) @(negedge clock);
    chk("oe", 1'b1, oe);
    chk("rx", 1'b1, rx_data);
    chk("tone", 8'h80, tone_out);
    sys_rst <= 1'b0;
    repeat (2490) @(negedge clock);
    chk("oe held", 1'b1, oe);
    repeat (20) @(negedge clock);
    chk("oe free", 1'b0, oe);
  endtask
  task automatic t_osc();
    repeat (4) @(negedge clock);
    chk("osc", !osc_in, osc_out);
    ext_sel <= 1'b1;
    repeat (3) @(negedge clock);
    chk("osc ext", 1'b0, osc_out);
    ext_sel <= 1'b0;
  endtask
  // mark on the idle line, then space during the start bit
  task automatic t_tx();
    int n;
    hi_run(n);
    chk_rng("mark", 8000, 11500, n);
    go <= 1'b1;
    @(negedge clock);
    go <= 1'b0;
    hi_run(n);
    chk_rng("space", 4000, 6900, n);
    chk("rx in tx", 1'b1, rx_data);
  endtask
  task automatic t_pin();
    ext_n <= 1'b0;
    repeat (4) @(negedge clock);
    chk("tone pin", 8'h80, tone_out);
    chk("rx pin", 1'b1, rx_data);
    ext_n <= 1'b1;
  endtask
  // space-rate square wave in receive mode: carrier and space bits must be detected
  task automatic t_rx();
    int i;
    req_send <= 1'b1;
    for (i = 0; i < 56; i++) begin
      tone_in <= (i % 18 < 9) ? 8'hb0 : 8'h50;
      repeat (625) @(negedge clock);
    end
    chk("cd", 1'b1, cd);
    chk("rx space", 1'b0, rx_data);
    chk("tone rx", 8'h80, tone_out);
    // mark rate, high first so the next rising edge spans a whole mark period
    for (i = 0; i < 36; i++) begin
      tone_in <= (i % 33 < 16) ? 8'hb0 : 8'h50;
      repeat (625) @(negedge clock);
    end
    chk("rx mark", 1'b1, rx_data);
  endtask
  initial begin
    t_reset();
    t_osc();
    t_tx();
    t_pin();
    t_rx();
    finish_test();
  end
  initial begin
    // tests need about 83k cycles: stretch, two tone halves, 92 receive samples
    repeat (98000) @(posedge clock);
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
